// file: src/ctfr_regs.vh
// Constants for the current and thermal fault response block.
`ifndef CTFR_REGS_VH
`define CTFR_REGS_VH
// Power stage states, one-hot.
`define CTFR_BR_ACTIVE 5'h01
`define CTFR_BR_RECIRC 5'h02
`define CTFR_BR_HIZ 5'h04
`define CTFR_BR_HSBRK 5'h08
`define CTFR_BR_LSBRK 5'h10
// Status bit positions.
`define CTFR_ST_CBC 0
`define CTFR_ST_LOCK 1
`define CTFR_ST_RISE_TO 2
`define CTFR_ST_FALL_TO 3
`define CTFR_ST_RATE 4
`define CTFR_ST_OTW 5
`define CTFR_ST_TSD 6
`define CTFR_ST_CTRL 7
// Timing: position detection timeout in ms, clock in MHz.
`define CTFR_IPD_TIMEOUT_MS 500
`define CTFR_CLK_MHZ 200
`define CTFR_IPD_TIMEOUT_CYC (`CTFR_IPD_TIMEOUT_MS * 1000 * `CTFR_CLK_MHZ)
// Default lock retry interval in ms.
`define CTFR_LOCK_RETRY_MS 1000
`define CTFR_LOCK_RETRY_CYC (`CTFR_LOCK_RETRY_MS * 1000 * `CTFR_CLK_MHZ)
`endif

// file: src/ctfr_fault_response.v
// Fault response logic: current limit, lock current, detection and thermal faults.
// Summary of operation
// (RULE_01) Sense above cycle limit raises cycle event.
// (RULE_02) Modes 0000/0001 recirculate, resume next PWM cycle.
// (RULE_03) 0000 reports until next cycle; 0001 silent.
// (RULE_04) Modes 0010/0011 recirculate until sense drops.
// (RULE_05) Modes 0100/0101 recirculate for retry cycle count.
// (RULE_06) Mode 0111 or 1xxx takes no action.
// (RULE_07) Mode 0110 sets status bit only, drives on.
// (RULE_08) Sense above lock limit raises lock event.
// (RULE_09) Lock mode 0101 recirculates, reports, retries later.
// (RULE_10) Lock modes latch, retry, report, or ignore.
// (RULE_11) Long detection ramp: Hi-Z, report, latch.
// (RULE_12) Early detection pulse: Hi-Z, report, latch.
// (RULE_13) Warning reports while driving, clears with command.
// (RULE_14) Shutdown forces Hi-Z, resumes automatically, status sticky.
`timescale 1ns/1ps
`include "ctfr_regs.vh"

module ctfr_fault_response #(
   parameter TIMEOUT_CYC = `CTFR_IPD_TIMEOUT_CYC,
   parameter LOCK_RETRY_CYC = `CTFR_LOCK_RETRY_CYC,
   parameter RETRY_W = 8
) (
   // Clock and reset.
   input wire SYS_CLK,
   input wire RSTN,
   // Comparator and core events.
   input wire CYCLE_CURRENT_LIMIT,
   input wire LOCK_CURRENT_LIMIT,
   input wire PWM_CYCLE_START,
   input wire RAMP_ACTIVE,
   input wire RAMP_FALLING,
   input wire DETECT_PULSE_START,
   input wire CURRENT_DECAYED,
   input wire THERMAL_WARNING,
   input wire THERMAL_SHUTDOWN,
   // Configuration.
   input wire [3:0] CYCLE_LIMIT_RESPONSE_SELECT,
   input wire [RETRY_W-1:0] CYCLE_LIMIT_RETRY_COUNT,
   input wire [3:0] LOCK_CURRENT_RESPONSE_SELECT,
   input wire THERMAL_WARNING_REPORT_ENABLE,
   input wire CLEAR_FAULT_COMMAND,
   // Results.
   output reg [4:0] BRIDGE_STATE,
   output wire FAULT_PIN_N,
   output reg [7:0] FAULT_STATUS
);

   // ****************************************
   // Cycle-by-cycle current limit
   // ****************************************
   wire [3:0] cm = CYCLE_LIMIT_RESPONSE_SELECT;
   wire cyc_prot = (cm[3:1] == 3'h0) || (cm[3:1] == 3'h1) || (cm[3:1] == 3'h2);
   wire cyc_rep = cyc_prot && !cm[0];
   reg cyc_act_ff;
   reg [RETRY_W:0] cyc_cnt_ff;
   reg [RETRY_W:0] nxt_cyc_cnt;
   reg nxt_cyc_act;

   // Decide when the recirculation episode ends; recovery depends on the mode group.
   always @* begin
      nxt_cyc_act = cyc_act_ff;
      nxt_cyc_cnt = cyc_cnt_ff;
      if (!cyc_prot) begin
         nxt_cyc_act = 1'b0; // RULE_06
      end else if (!cyc_act_ff) begin
         if (CYCLE_CURRENT_LIMIT) begin // RULE_01
            nxt_cyc_act = 1'b1;
            nxt_cyc_cnt = {(RETRY_W+1){1'b0}};
         end
      end else begin
         case (cm[2:1])
            2'b00: if (PWM_CYCLE_START) nxt_cyc_act = 1'b0; // RULE_02
            2'b01: if (!CYCLE_CURRENT_LIMIT) nxt_cyc_act = 1'b0; // RULE_04
            default: begin
               if (PWM_CYCLE_START) begin
                  nxt_cyc_cnt = cyc_cnt_ff + 1'b1;
                  // Resume once the elapsed count exceeds the programmed count.
                  if (nxt_cyc_cnt > {1'b0, CYCLE_LIMIT_RETRY_COUNT})
                     nxt_cyc_act = 1'b0; // RULE_05
               end
            end
         endcase
      end
   end

   // Episode state registers.
   always @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         cyc_act_ff <= 1'b0;
         cyc_cnt_ff <= {(RETRY_W+1){1'b0}};
      end else begin
         cyc_act_ff <= nxt_cyc_act;
         cyc_cnt_ff <= nxt_cyc_cnt;
      end
   end

   wire cyc_report = cyc_act_ff && cyc_rep; // RULE_03
   wire cyc_flag_only = (cm == 4'h6) && CYCLE_CURRENT_LIMIT; // RULE_07

   // ****************************************
   // Lock-detection current limit
   // ****************************************
   wire [3:0] lm = LOCK_CURRENT_RESPONSE_SELECT;
   wire lock_none = lm[3] && lm[0]; // RULE_10
   wire lock_rep_only = (lm == 4'h8);
   wire lock_prot = !lm[3];
   reg lock_act_ff;
   reg [31:0] lock_tmr_ff;

   // Lock episode: latched modes wait for clear, retry modes for the interval.
   always @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         lock_act_ff <= 1'b0;
         lock_tmr_ff <= 32'h0;
      end else if (!lock_act_ff) begin
         lock_tmr_ff <= 32'h0;
         if (lock_prot && LOCK_CURRENT_LIMIT) // RULE_08
            lock_act_ff <= 1'b1;
      end else if (!lm[2]) begin
         // A clear while the sense output still stands above the limit is ignored,
         // so the latch cannot drop for one cycle and then re-arm.
         if ((CLEAR_FAULT_COMMAND && !LOCK_CURRENT_LIMIT) || !lock_prot)
            lock_act_ff <= 1'b0; // RULE_10
      end else begin
         lock_tmr_ff <= lock_tmr_ff + 32'h1;
         if (lock_tmr_ff >= LOCK_RETRY_CYC - 1)
            lock_act_ff <= 1'b0; // RULE_09
      end
   end

   // ****************************************
   // Position detection faults
   // ****************************************
   reg [31:0] ramp_tmr_ff;
   reg ipd_fault_ff;

   // A ramp that outlasts the timeout or a premature pulse latches Hi-Z.
   always @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         ramp_tmr_ff <= 32'h0;
         ipd_fault_ff <= 1'b0;
      end else begin
         ramp_tmr_ff <= RAMP_ACTIVE ? ramp_tmr_ff + 32'h1 : 32'h0;
         if ((RAMP_ACTIVE && ramp_tmr_ff >= TIMEOUT_CYC - 1) ||
             (DETECT_PULSE_START && !CURRENT_DECAYED))
            ipd_fault_ff <= 1'b1; // RULE_11 RULE_12
         else if (CLEAR_FAULT_COMMAND)
            ipd_fault_ff <= 1'b0;
      end
   end

   // ****************************************
   // Status, pin and bridge
   // ****************************************
   reg [7:0] nxt_status;
   wire ramp_to = RAMP_ACTIVE && ramp_tmr_ff >= TIMEOUT_CYC - 1;
   wire otw_ev = THERMAL_WARNING && THERMAL_WARNING_REPORT_ENABLE;
   // Only the protective codes and the report-only code record a lock event.
   wire lock_ev = LOCK_CURRENT_LIMIT && (lock_prot || lock_rep_only) && !lock_none; // RULE_10
   wire ctrl_ev = cyc_report || cyc_flag_only || lock_ev || otw_ev ||
                  THERMAL_SHUTDOWN || ramp_to || (DETECT_PULSE_START && !CURRENT_DECAYED);

   // Sticky bits 1 to 6; a new event in the clearing cycle wins over the clear.
   always @* begin
      nxt_status = CLEAR_FAULT_COMMAND ? 8'h00 : FAULT_STATUS;
      nxt_status[`CTFR_ST_CBC] = cyc_act_ff || cyc_flag_only; // RULE_02
      if (lock_ev) nxt_status[`CTFR_ST_LOCK] = 1'b1;
      if (ramp_to && !RAMP_FALLING) nxt_status[`CTFR_ST_RISE_TO] = 1'b1;
      if (ramp_to && RAMP_FALLING) nxt_status[`CTFR_ST_FALL_TO] = 1'b1;
      if (DETECT_PULSE_START && !CURRENT_DECAYED) nxt_status[`CTFR_ST_RATE] = 1'b1;
      if (otw_ev) nxt_status[`CTFR_ST_OTW] = 1'b1; // RULE_13
      if (THERMAL_SHUTDOWN) nxt_status[`CTFR_ST_TSD] = 1'b1; // RULE_14
      // The cycle limit report in modes 0000, 0010 and 0100 follows the episode.
      if (ctrl_ev || (!CLEAR_FAULT_COMMAND && FAULT_STATUS[`CTFR_ST_CTRL] &&
          (nxt_status[6:1] != 6'h00)))
         nxt_status[`CTFR_ST_CTRL] = 1'b1;
      else
         nxt_status[`CTFR_ST_CTRL] = cyc_report;
   end

   // Pin is low while any reporting fault stands; lock report-only stays off the pin.
   // The pin is registered with the status and only while a status bit stands, so a
   // clear releases both on one edge; a clear during a running lock retry therefore
   // releases the pin before the retry ends.
   wire pin_low = cyc_report || (lock_act_ff) || ipd_fault_ff || THERMAL_SHUTDOWN ||
                  (THERMAL_WARNING_REPORT_ENABLE && FAULT_STATUS[`CTFR_ST_OTW]);
   reg pin_low_ff;
   assign FAULT_PIN_N = !pin_low_ff;

   // Bridge priority: Hi-Z faults first, then lock state, then recirculation.
   reg [4:0] nxt_bridge;
   always @* begin
      nxt_bridge = `CTFR_BR_ACTIVE;
      if (ipd_fault_ff || THERMAL_SHUTDOWN) begin
         nxt_bridge = `CTFR_BR_HIZ; // RULE_11 RULE_14
      end else if (lock_act_ff) begin
         case (lm[1:0])
            2'b00: nxt_bridge = `CTFR_BR_HIZ;
            2'b01: nxt_bridge = `CTFR_BR_RECIRC; // RULE_09
            2'b10: nxt_bridge = `CTFR_BR_HSBRK;
            default: nxt_bridge = `CTFR_BR_LSBRK;
         endcase
      end else if (cyc_act_ff) begin
         nxt_bridge = `CTFR_BR_RECIRC;
      end
   end

   // Output registers.
   always @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         FAULT_STATUS <= 8'h00;
         BRIDGE_STATE <= `CTFR_BR_ACTIVE;
         pin_low_ff <= 1'b0;
      end else begin
         FAULT_STATUS <= nxt_status;
         BRIDGE_STATE <= nxt_bridge;
         pin_low_ff <= pin_low && (nxt_status != 8'h00);
      end
   end

endmodule

// file: verif/ctfr_host_mon.sv
// Host model that counts fault alerts on the fault pin.
`timescale 1ns/1ps
// ***
// Host fault monitor
// ***
module ctfr_host_mon (
   // Clock, reset and watched pin.
   input wire sys_clk,
   input wire rstn,
   input wire fault_pin_n,
   // One count per falling edge.
   output reg [7:0] alerts
);
   reg last_ff;
   // Edges, not levels, so a long fault counts once.
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         last_ff <= 1'b1;
         alerts <= 8'h00;
      end else begin
         last_ff <= fault_pin_n;
         if (last_ff && !fault_pin_n)
            alerts <= alerts + 8'h01;
      end
   end
endmodule

// file: verif/ctfr_fault_response_chk.sv
// Port checks for the fault response block.
`timescale 1ns/1ps
`include "ctfr_regs.vh"
// ***
// Checker
// ***
module ctfr_fault_response_chk (
   // Watched ports.
   input wire SYS_CLK, RSTN, CYCLE_CURRENT_LIMIT, LOCK_CURRENT_LIMIT, PWM_CYCLE_START,
   input wire RAMP_ACTIVE, DETECT_PULSE_START, THERMAL_WARNING, THERMAL_SHUTDOWN,
   input wire CLEAR_FAULT_COMMAND, FAULT_PIN_N,
   input wire [3:0] CYCLE_LIMIT_RESPONSE_SELECT,
   input wire [4:0] BRIDGE_STATE,
   input wire [7:0] FAULT_STATUS
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RSTN);
   // Other sources idle, so only the cycle limit, or a lock retry still running after a clear, can move the outputs.
   wire calm = !LOCK_CURRENT_LIMIT && !THERMAL_WARNING && !THERMAL_SHUTDOWN && !RAMP_ACTIVE &&
      !DETECT_PULSE_START && FAULT_STATUS[6:1] == 6'h00;
   wire [3:0] sel = CYCLE_LIMIT_RESPONSE_SELECT;
   sequence s_trip;
      calm && CYCLE_CURRENT_LIMIT && sel == 4'h0 && !PWM_CYCLE_START ##1 calm && !PWM_CYCLE_START;
   endsequence
   sequence s_release;
      calm && PWM_CYCLE_START && !CYCLE_CURRENT_LIMIT && sel[3:1] == 3'h0 ##1 calm;
   endsequence
   a_bridge_one_hot: assert property ($onehot(BRIDGE_STATE))
      else $error("bridge state not one-hot");
   a_pin_has_cause: assert property (!FAULT_PIN_N |-> FAULT_STATUS != 8'h00)
      else $error("fault pin low, status empty");
   a_cbc_trip_report: assert property (s_trip |-> ##1
      BRIDGE_STATE == `CTFR_BR_RECIRC && !FAULT_PIN_N && FAULT_STATUS[0] && FAULT_STATUS[7])
      else $error("cycle limit trip wrong");
   a_cbc_next_cycle: assert property (s_release |-> ##1
      BRIDGE_STATE == `CTFR_BR_ACTIVE && FAULT_PIN_N && !FAULT_STATUS[0])
      else $error("no resume on new cycle");
   a_cbc_mode_ignored: assert property ((calm && CYCLE_CURRENT_LIMIT && sel[3])[*3] |->
      BRIDGE_STATE == `CTFR_BR_ACTIVE && FAULT_PIN_N)
      else $error("ignored mode acted");
   a_tsd_forces_hiz: assert property (THERMAL_SHUTDOWN[*3] |-> BRIDGE_STATE == `CTFR_BR_HIZ)
      else $error("shutdown not Hi-Z");
   a_tsd_reports: assert property (THERMAL_SHUTDOWN |-> ##1
      FAULT_STATUS[`CTFR_ST_TSD] && !FAULT_PIN_N)
      else $error("shutdown not reported");
   a_status_sticky: assert property ((!CLEAR_FAULT_COMMAND)[*3] |->
      ($past(FAULT_STATUS[6:1]) & ~FAULT_STATUS[6:1]) == 6'h00)
      else $error("status bit dropped without clear");
endmodule
bind ctfr_fault_response ctfr_fault_response_chk CHK (.SYS_CLK(SYS_CLK), .RSTN(RSTN),
   .CYCLE_CURRENT_LIMIT(CYCLE_CURRENT_LIMIT), .LOCK_CURRENT_LIMIT(LOCK_CURRENT_LIMIT),
   .PWM_CYCLE_START(PWM_CYCLE_START), .RAMP_ACTIVE(RAMP_ACTIVE),
   .DETECT_PULSE_START(DETECT_PULSE_START), .THERMAL_WARNING(THERMAL_WARNING),
   .THERMAL_SHUTDOWN(THERMAL_SHUTDOWN), .CLEAR_FAULT_COMMAND(CLEAR_FAULT_COMMAND),
   .FAULT_PIN_N(FAULT_PIN_N), .CYCLE_LIMIT_RESPONSE_SELECT(CYCLE_LIMIT_RESPONSE_SELECT),
   .BRIDGE_STATE(BRIDGE_STATE), .FAULT_STATUS(FAULT_STATUS));

// file: verif/ctfr_fault_response_tb.sv
// Self-checking bench for the fault response block.
`timescale 1ns/1ps
`include "ctfr_regs.vh"
// ***
// Bench
// ***
module ctfr_fault_response_tb;
   reg clk = 1'b0, rstn = 1'b0, cl = 1'b0, ll = 1'b0, pwm = 1'b0, ramp = 1'b0, fall = 1'b0;
   reg det = 1'b0, dec = 1'b1, warn = 1'b0, thermal_shutdown = 1'b0, wen = 1'b0, clr = 1'b0;
   reg [3:0] csel = 4'h7, lsel = 4'h9;
   reg [4:0] eb;
   wire [4:0] bridge;
   wire pin_n;
   wire [7:0] st, alerts;
   integer n_errors = 0, cmp_count = 0, ticks = 0, i, k;
   // Counts are shortened so every timed recovery fits a short run.
   ctfr_fault_response #(.TIMEOUT_CYC(50), .LOCK_RETRY_CYC(40), .RETRY_W(8)) DUT (
      .SYS_CLK(clk), .RSTN(rstn), .CYCLE_CURRENT_LIMIT(cl), .LOCK_CURRENT_LIMIT(ll),
      .PWM_CYCLE_START(pwm), .RAMP_ACTIVE(ramp), .RAMP_FALLING(fall), .DETECT_PULSE_START(det),
      .CURRENT_DECAYED(dec), .THERMAL_WARNING(warn), .THERMAL_SHUTDOWN(thermal_shutdown),
      .CYCLE_LIMIT_RESPONSE_SELECT(csel), .CYCLE_LIMIT_RETRY_COUNT(8'h02),
      .LOCK_CURRENT_RESPONSE_SELECT(lsel), .THERMAL_WARNING_REPORT_ENABLE(wen),
      .CLEAR_FAULT_COMMAND(clr), .BRIDGE_STATE(bridge), .FAULT_PIN_N(pin_n), .FAULT_STATUS(st));
   ctfr_host_mon HOST (.sys_clk(clk), .rstn(rstn), .fault_pin_n(pin_n), .alerts(alerts));
   // Clock and hang guard.
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) begin
      ticks = ticks + 1;
      if (ticks == 5000) begin
         n_errors = n_errors + 1;
         summarize;
      end
   end
   task cyc(input integer n);
      repeat (n) @(negedge clk);
   endtask
   task chk(input string nm, input [15:0] seen, input [15:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("ERROR %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task strobe(input integer which);
      begin
         if (which) clr = 1'b1; else pwm = 1'b1;
         cyc(1);
         clr = 1'b0;
         pwm = 1'b0;
         cyc(3);
      end
   endtask
   // Every cycle-limit code: held event, then four new PWM cycles.
   task t_cbc;
      for (i = 0; i < 16; i = i + 1) begin
         csel = i[3:0];
         cl = 1'b1;
         cyc(3);
         eb = (i < 6) ? `CTFR_BR_RECIRC : `CTFR_BR_ACTIVE;
         chk("cbc bridge", bridge, eb);
         chk("cbc pin", pin_n, (i < 6) ? i[0] : 1'b1);
         chk("cbc ctrl", st[`CTFR_ST_CTRL], (i < 7) ? !i[0] : 1'b0);
         cl = 1'b0;
         repeat (4) strobe(0);
         chk("cbc resume", {bridge, pin_n, st[0]}, {`CTFR_BR_ACTIVE, 2'b10});
         strobe(1);
      end
   endtask
   // Every lock code: state, report, then retry or latch, then clear.
   task t_lock;
      for (i = 0; i < 16; i = i + 1) begin
         lsel = i[3:0];
         ll = 1'b1;
         cyc(3);
         eb = `CTFR_BR_ACTIVE;
         if (i < 8) eb = {i[1:0] == 2'h3, i[1:0] == 2'h2, i[1:0] == 2'h0, i[1:0] == 2'h1, 1'b0};
         chk("lock bridge", bridge, eb);
         chk("lock rep", {pin_n, st[`CTFR_ST_CTRL], st[`CTFR_ST_LOCK]},
            {i > 7, i < 9, i < 9});
         ll = 1'b0;
         cyc(45);
         chk("lock retry", bridge, (i > 3 && i < 8) ? `CTFR_BR_ACTIVE : eb);
         strobe(1);
         chk("lock clear", {bridge, st}, {`CTFR_BR_ACTIVE, 8'h00});
      end
   endtask
   // One case per call, chosen by k: rise ramp timeout, fall ramp timeout or early detection pulse.
   task t_ipd;
      begin
         fall = (k == 1);
         ramp = (k < 2);
         dec = 1'b0;
         cyc(45);
         chk("ipd early", bridge, `CTFR_BR_ACTIVE);
         det = (k == 2);
         cyc(1);
         det = 1'b0;
         cyc(12);
         ramp = 1'b0;
         dec = 1'b1;
         chk("ipd trip", {bridge, pin_n, st}, {`CTFR_BR_HIZ, 9'h080 | (9'h004 << k)});
         strobe(1);
         chk("ipd clear", {bridge, pin_n, st}, {`CTFR_BR_ACTIVE, 9'h100});
      end
   endtask
   // Warning masked, reported and held, then shutdown and its recovery.
   task t_thermal;
      begin
         warn = 1'b1;
         cyc(3);
         chk("warn masked", {pin_n, st}, 9'h100);
         wen = 1'b1;
         cyc(3);
         warn = 1'b0;
         cyc(3);
         chk("warn held", {bridge, pin_n, st[5]}, {`CTFR_BR_ACTIVE, 2'b01});
         strobe(1);
         chk("warn clear", {pin_n, st}, 9'h100);
         thermal_shutdown = 1'b1;
         cyc(3);
         chk("tsd trip", {bridge, pin_n, st[6]}, {`CTFR_BR_HIZ, 2'b01});
         thermal_shutdown = 1'b0;
         cyc(3);
         chk("tsd resume", {bridge, st[6]}, {`CTFR_BR_ACTIVE, 1'b1});
         strobe(1);
         chk("tsd clear", st, 8'h00);
      end
   endtask
   task summarize;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
         if (n_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   initial begin
      cyc(2);
      chk("reset", {bridge, pin_n, st}, {`CTFR_BR_ACTIVE, 9'h100});
      rstn = 1'b1;
      cyc(2);
      t_cbc;
      t_lock;
      for (k = 0; k < 3; k = k + 1) t_ipd;
      t_thermal;
      chk("host alerts", alerts, 8'h10);
      summarize;
   end
endmodule
